// *** shared/timer8_defs.vh ***
`ifndef TIMER8_DEFS_VH
`define TIMER8_DEFS_VH

// Word offsets of the register words on the bus, decoded from address bits 4:2.
`define OFS_CTRL_A 3'h0
`define OFS_CTRL_B 3'h1
`define OFS_COUNT 3'h2
`define OFS_CMP_A 3'h3
`define OFS_CMP_B 3'h4
`define OFS_FLAGS 3'h5
`define OFS_IRQ_EN 3'h6
`define OFS_PORT 3'h7

// Field positions in control_reg_a.
`define CA_COM_A_HI 7
`define CA_COM_A_LO 6
`define CA_COM_B_HI 5
`define CA_COM_B_LO 4
`define CA_WGM_HI 1
`define CA_WGM_LO 0

// Field positions in control_reg_b.
`define CB_FORCE_A 7
`define CB_FORCE_B 6
`define CB_WGM2 3
`define CB_CS_HI 2
`define CB_CS_LO 0

// Field positions in the flag and enable registers.
`define FL_OVF 0
`define FL_CMP_A 1
`define FL_CMP_B 2

// Field positions in the port register.
`define PT_DATA_A 0
`define PT_DATA_B 1
`define PT_DIR_A 4
`define PT_DIR_B 5

// Reset values.
`define RST_BYTE 8'h00
`define RST_WAIT 1'b1

// Counter extremes.
`define CNT_BOTTOM 8'h00
`define CNT_MAX 8'hFF

// Clock source select codes.
`define CS_STOP 3'h0
`define CS_DIV1 3'h1
`define CS_DIV8 3'h2
`define CS_DIV64 3'h3
`define CS_DIV256 3'h4
`define CS_DIV1024 3'h5
`define CS_EXT_FALL 3'h6
`define CS_EXT_RISE 3'h7

// Prescaler tap terminal counts.
`define PRE_WIDTH 10
`define PRE_TAP8 10'h007
`define PRE_TAP64 10'h03F
`define PRE_TAP256 10'h0FF
`define PRE_TAP1024 10'h3FF

// Waveform mode codes.
`define WGM_NORMAL 3'h0
`define WGM_PC_MAX 3'h1
`define WGM_CTC 3'h2
`define WGM_FAST_MAX 3'h3
`define WGM_PC_CMP 3'h5
`define WGM_FAST_CMP 3'h7

`endif

// *** verilog/timer8_counter_compare_core.v ***
// Contract
// - Eight-bit counter counting up or down, with clear, top and bottom indications.
// - Each timer clock enable clears, increments or decrements the counter per mode.
// - Clock source select zero stops the timer clock; the counter holds.
// - Software may read and write the counter at any time.
// - A software counter write beats any clear or count in that cycle.
// - Mode comes from two bits in control A and one bit in control B.
// - Overflow flag is set per mode and can request an interrupt.
// - Comparator flags equality of counter with compare value A and B continuously.
// - A compare match sets its flag on the following timer clock.
// - An enabled, set compare flag raises a compare interrupt request.
// - Compare flag clears on interrupt service or when software writes one.
// - PWM modes double buffer compare values, loaded at top or bottom.
// - Compare accesses use the buffer when buffering, else the active register.
// - Force strobe in non-PWM modes updates output only, no flag, no clear.
// - A counter write blocks compare matches in the next timer clock.
// - Waveform output bits keep their values across waveform mode changes.
// - Output mode bits are unbuffered and apply from the next match.
// - Reset clears each waveform output bit to zero.
// - Nonzero output mode replaces port data; direction stays with port.
// - Output mode zero leaves the waveform output bit unchanged on match.
// - Bottom is 0x00, maximum 0xFF; top is maximum or compare A.
// - Select one runs at system rate; two to five pick taps 8..1024.
// - Selects seven and six count rising or falling external input edges.
//
// The implementer's own choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "timer8_defs.vh"

module timer8_counter_compare_core (
    input wire sys_clk,
    input wire rst_n,
    input wire clk_en,
    input wire [4:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    input wire [3:0] avs_byteenable,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire external_count_input,
    input wire ack_ovf,
    input wire ack_cmp_a,
    input wire ack_cmp_b,
    output reg irq_ovf,
    output reg irq_cmp_a,
    output reg irq_cmp_b,
    output reg waveform_output_a,
    output reg waveform_output_b,
    output reg pin_a_out,
    output reg pin_a_oe_n,
    output reg pin_b_out,
    output reg pin_b_oe_n
);

    reg [7:0] count_value_q;
    reg [7:0] count_value_d;
    reg dir_down_q;
    reg dir_down_d;
    reg [1:0] com_a_q;
    reg [1:0] com_b_q;
    reg [2:0] waveform_mode_q;
    reg [2:0] clock_source_select_q;
    reg [7:0] compare_value_a_q;
    reg [7:0] compare_value_b_q;
    reg [7:0] buf_a_q;
    reg [7:0] buf_b_q;
    reg overflow_flag_q;
    reg compare_flag_a_q;
    reg compare_flag_b_q;
    reg [2:0] irq_en_q;
    reg [1:0] port_data_q;
    reg [1:0] port_dir_q;
    reg [1:0] oc_q;
    reg block_q;
    reg [9:0] pre_q;
    reg ext_meta_q;
    reg ext_sync_q;
    reg ext_prev_q;
    reg timer_clock_enable;
    reg ovf_set;
    reg upd_ev;
    reg bot_ev;
    reg [31:0] rdata;

    wire bus_req = avs_read | avs_write;
    wire acc = bus_req & ~avs_waitrequest;
    wire wr_en = acc & avs_write & avs_byteenable[0];
    wire [2:0] word = avs_address[4:2];
    wire [7:0] wdata = avs_writedata[7:0];
    wire wr_ctrl_a = wr_en & (word == `OFS_CTRL_A);
    wire wr_ctrl_b = wr_en & (word == `OFS_CTRL_B);
    wire wr_count = wr_en & (word == `OFS_COUNT);
    wire wr_cmp_a = wr_en & (word == `OFS_CMP_A);
    wire wr_cmp_b = wr_en & (word == `OFS_CMP_B);
    wire wr_flags = wr_en & (word == `OFS_FLAGS);
    wire wr_irq_en = wr_en & (word == `OFS_IRQ_EN);
    wire wr_port = wr_en & (word == `OFS_PORT);

    wire pwm = waveform_mode_q[0];
    wire phase_mode = pwm & ~waveform_mode_q[1];
    wire fast_mode = pwm & waveform_mode_q[1];
    wire top_is_cmp = (waveform_mode_q == `WGM_CTC) | (waveform_mode_q == `WGM_PC_CMP) |
        (waveform_mode_q == `WGM_FAST_CMP);
    wire [7:0] top_value = top_is_cmp ? compare_value_a_q : `CNT_MAX;
    wire at_top = (count_value_q == top_value);
    wire at_bottom = (count_value_q == `CNT_BOTTOM);
    wire at_max = (count_value_q == `CNT_MAX);

    wire [1:0] match = {count_value_q == compare_value_b_q,
        count_value_q == compare_value_a_q};
    wire [1:0] match_ev = match & {2{timer_clock_enable & ~block_q}};
    wire [1:0] force_ev = {wr_ctrl_b & wdata[`CB_FORCE_B],
        wr_ctrl_b & wdata[`CB_FORCE_A]} & {2{~pwm}};
    wire [3:0] com_pk = {com_b_q, com_a_q};
    wire [1:0] toggle_ok = {1'b0, waveform_mode_q[2]};
    wire [1:0] oc_d;

    // Timer clock enable from the selected source; one system cycle wide.
    always @* begin
        case (clock_source_select_q)
            `CS_STOP: timer_clock_enable = 1'b0;
            `CS_DIV1: timer_clock_enable = 1'b1;
            `CS_DIV8: timer_clock_enable = ({7'h00, pre_q[2:0]} == `PRE_TAP8);
            `CS_DIV64: timer_clock_enable = ({4'h0, pre_q[5:0]} == `PRE_TAP64);
            `CS_DIV256: timer_clock_enable = ({2'h0, pre_q[7:0]} == `PRE_TAP256);
            `CS_DIV1024: timer_clock_enable = (pre_q == `PRE_TAP1024);
            `CS_EXT_FALL: timer_clock_enable = ext_prev_q & ~ext_sync_q;
            `CS_EXT_RISE: timer_clock_enable = ~ext_prev_q & ext_sync_q;
            default: timer_clock_enable = 1'b0;
        endcase
    end

    // Counter sequencing per waveform mode.
    always @* begin
        count_value_d = count_value_q;
        dir_down_d = dir_down_q;
        ovf_set = 1'b0;
        upd_ev = 1'b0;
        bot_ev = 1'b0;
        if (!phase_mode) begin
            dir_down_d = 1'b0;
        end
        if (timer_clock_enable) begin
            if (fast_mode) begin
                if (at_top) begin
                    count_value_d = `CNT_BOTTOM;
                    ovf_set = 1'b1;
                    upd_ev = 1'b1;
                    bot_ev = 1'b1;
                end else begin
                    count_value_d = count_value_q + 8'h01;
                end
            end else if (phase_mode) begin
                if (!dir_down_q) begin
                    if (at_top) begin
                        dir_down_d = 1'b1;
                        count_value_d = count_value_q - 8'h01;
                        upd_ev = 1'b1;
                    end else begin
                        count_value_d = count_value_q + 8'h01;
                    end
                end else begin
                    if (at_bottom) begin
                        dir_down_d = 1'b0;
                        count_value_d = count_value_q + 8'h01;
                        ovf_set = 1'b1;
                    end else begin
                        count_value_d = count_value_q - 8'h01;
                    end
                end
            end else if (waveform_mode_q == `WGM_CTC) begin
                count_value_d = at_top ? `CNT_BOTTOM : count_value_q + 8'h01;
                ovf_set = at_max;
            end else begin
                count_value_d = count_value_q + 8'h01;
                ovf_set = at_max;
            end
        end
        if (wr_count) begin
            count_value_d = wdata;
        end
    end

    // Per compare unit waveform output next value.
    genvar i;
    generate
        for (i = 0; i < 2; i = i + 1) begin : g_unit
            reg oc_n;
            always @* begin
                oc_n = oc_q[i];
                if (fast_mode) begin
                    if (bot_ev && com_pk[2*i+1]) begin
                        oc_n = ~com_pk[2*i];
                    end else if (match_ev[i]) begin
                        case (com_pk[2*i+:2])
                            2'h1: oc_n = toggle_ok[i] ? ~oc_q[i] : oc_q[i];
                            2'h2: oc_n = 1'b0;
                            2'h3: oc_n = 1'b1;
                            default: oc_n = oc_q[i];
                        endcase
                    end
                end else if (phase_mode) begin
                    if (match_ev[i]) begin
                        case (com_pk[2*i+:2])
                            2'h1: oc_n = toggle_ok[i] ? ~oc_q[i] : oc_q[i];
                            2'h2: oc_n = dir_down_q;
                            2'h3: oc_n = ~dir_down_q;
                            default: oc_n = oc_q[i];
                        endcase
                    end
                end else if (match_ev[i] || force_ev[i]) begin
                    case (com_pk[2*i+:2])
                        2'h1: oc_n = ~oc_q[i];
                        2'h2: oc_n = 1'b0;
                        2'h3: oc_n = 1'b1;
                        default: oc_n = oc_q[i];
                    endcase
                end
            end
            assign oc_d[i] = oc_n;
        end
    endgenerate

    // Register read multiplexer; unmapped words read as zero.
    always @* begin
        rdata = 32'h0000_0000;
        case (word)
            `OFS_CTRL_A: rdata[7:0] = {com_a_q, com_b_q, 2'h0, waveform_mode_q[1:0]};
            `OFS_CTRL_B: rdata[7:0] = {4'h0, waveform_mode_q[2], clock_source_select_q};
            `OFS_COUNT: rdata[7:0] = count_value_q;
            `OFS_CMP_A: rdata[7:0] = pwm ? buf_a_q : compare_value_a_q;
            `OFS_CMP_B: rdata[7:0] = pwm ? buf_b_q : compare_value_b_q;
            `OFS_FLAGS: rdata[7:0] = {5'h00, compare_flag_b_q, compare_flag_a_q,
                overflow_flag_q};
            `OFS_IRQ_EN: rdata[7:0] = {5'h00, irq_en_q};
            `OFS_PORT: rdata[7:0] = {2'h0, port_dir_q, 2'h0, port_data_q};
            default: rdata = 32'h0000_0000;
        endcase
    end

    always @(posedge sys_clk) begin
        if (!rst_n) begin
            avs_waitrequest <= `RST_WAIT;
            avs_readdata <= 32'h0000_0000;
            count_value_q <= `RST_BYTE;
            dir_down_q <= 1'b0;
            com_a_q <= 2'h0;
            com_b_q <= 2'h0;
            waveform_mode_q <= `WGM_NORMAL;
            clock_source_select_q <= `CS_STOP;
            compare_value_a_q <= `RST_BYTE;
            compare_value_b_q <= `RST_BYTE;
            buf_a_q <= `RST_BYTE;
            buf_b_q <= `RST_BYTE;
            overflow_flag_q <= 1'b0;
            compare_flag_a_q <= 1'b0;
            compare_flag_b_q <= 1'b0;
            irq_en_q <= 3'h0;
            port_data_q <= 2'h0;
            port_dir_q <= 2'h0;
            oc_q <= 2'h0;
            block_q <= 1'b0;
            pre_q <= 10'h000;
            ext_meta_q <= 1'b0;
            ext_sync_q <= 1'b0;
            ext_prev_q <= 1'b0;
            irq_ovf <= 1'b0;
            irq_cmp_a <= 1'b0;
            irq_cmp_b <= 1'b0;
            waveform_output_a <= 1'b0;
            waveform_output_b <= 1'b0;
            pin_a_out <= 1'b0;
            pin_a_oe_n <= 1'b1;
            pin_b_out <= 1'b0;
            pin_b_oe_n <= 1'b1;
        end else if (clk_en) begin
            // One wait cycle, then a single accept cycle per request.
            avs_waitrequest <= ~(bus_req & avs_waitrequest);
            if (bus_req && avs_waitrequest && avs_read) begin
                avs_readdata <= rdata;
            end
            pre_q <= pre_q + 10'h001;
            ext_meta_q <= external_count_input;
            ext_sync_q <= ext_meta_q;
            ext_prev_q <= ext_sync_q;
            count_value_q <= count_value_d;
            dir_down_q <= dir_down_d;
            if (wr_count) begin
                block_q <= 1'b1;
            end else if (timer_clock_enable) begin
                block_q <= 1'b0;
            end
            if (wr_ctrl_a) begin
                com_a_q <= wdata[`CA_COM_A_HI:`CA_COM_A_LO];
                com_b_q <= wdata[`CA_COM_B_HI:`CA_COM_B_LO];
                waveform_mode_q[1:0] <= wdata[`CA_WGM_HI:`CA_WGM_LO];
            end
            if (wr_ctrl_b) begin
                waveform_mode_q[2] <= wdata[`CB_WGM2];
                clock_source_select_q <= wdata[`CB_CS_HI:`CB_CS_LO];
            end
            if (wr_cmp_a) begin
                buf_a_q <= wdata;
            end
            if (wr_cmp_b) begin
                buf_b_q <= wdata;
            end
            if (wr_cmp_a && !pwm) begin
                compare_value_a_q <= wdata;
            end else if (pwm && upd_ev) begin
                compare_value_a_q <= buf_a_q;
            end
            if (wr_cmp_b && !pwm) begin
                compare_value_b_q <= wdata;
            end else if (pwm && upd_ev) begin
                compare_value_b_q <= buf_b_q;
            end
            // A new event outranks a clear in the same cycle.
            overflow_flag_q <= ovf_set | (overflow_flag_q &
                ~(ack_ovf | (wr_flags & wdata[`FL_OVF])));
            compare_flag_a_q <= match_ev[0] | (compare_flag_a_q &
                ~(ack_cmp_a | (wr_flags & wdata[`FL_CMP_A])));
            compare_flag_b_q <= match_ev[1] | (compare_flag_b_q &
                ~(ack_cmp_b | (wr_flags & wdata[`FL_CMP_B])));
            if (wr_irq_en) begin
                irq_en_q <= wdata[2:0];
            end
            if (wr_port) begin
                port_data_q <= {wdata[`PT_DATA_B], wdata[`PT_DATA_A]};
                port_dir_q <= {wdata[`PT_DIR_B], wdata[`PT_DIR_A]};
            end
            oc_q <= oc_d;
            irq_ovf <= overflow_flag_q & irq_en_q[`FL_OVF];
            irq_cmp_a <= compare_flag_a_q & irq_en_q[`FL_CMP_A];
            irq_cmp_b <= compare_flag_b_q & irq_en_q[`FL_CMP_B];
            waveform_output_a <= oc_q[0];
            waveform_output_b <= oc_q[1];
            pin_a_out <= (com_a_q != 2'h0) ? oc_q[0] : port_data_q[0];
            pin_b_out <= (com_b_q != 2'h0) ? oc_q[1] : port_data_q[1];
            pin_a_oe_n <= ~port_dir_q[0];
            pin_b_oe_n <= ~port_dir_q[1];
        end
    end

endmodule // timer8_counter_compare_core

// *** sim/timer8_counter_compare_core_chk.sv ***
`timescale 1ns/100ps
module timer8_chk (
    input logic sys_clk,
    input logic rst_n,
    input logic clk_en,
    input logic [4:0] avs_address,
    input logic avs_read,
    input logic avs_write,
    input logic [31:0] avs_writedata,
    input logic [3:0] avs_byteenable,
    input logic [31:0] avs_readdata,
    input logic avs_waitrequest,
    input logic external_count_input,
    input logic ack_ovf,
    input logic ack_cmp_a,
    input logic ack_cmp_b,
    input logic irq_ovf,
    input logic irq_cmp_a,
    input logic irq_cmp_b,
    input logic waveform_output_a,
    input logic waveform_output_b,
    input logic pin_a_out,
    input logic pin_a_oe_n,
    input logic pin_b_out,
    input logic pin_b_oe_n
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n || !clk_en);
    logic req;
    logic wr_ok;
    logic wr_port;
    logic wr_src;
    logic wr_irq;
    logic rd_ok;
    assign req = avs_read || avs_write;
    assign wr_ok = avs_write && !avs_waitrequest && avs_byteenable[0];
    assign wr_port = wr_ok && avs_address[4:2] == 3'h7;
    assign wr_src = wr_port || (wr_ok && avs_address[4:2] <= 3'h1);
    assign wr_irq = wr_ok && (avs_address[4:2] == 3'h5 || avs_address[4:2] == 3'h6);
    assign rd_ok = avs_read && !avs_waitrequest;
    // A request is answered after one cycle, and the answer lasts one cycle.
    sequence s_answer;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence
    chk_reset_vals: assert property (disable iff (1'b0)
        !rst_n |=> avs_waitrequest && pin_a_oe_n && pin_b_oe_n && !waveform_output_a
        && !waveform_output_b && !irq_cmp_a && !irq_ovf)
        else $error("outputs not at reset values");
    chk_bus_answer: assert property (req && avs_waitrequest |=> s_answer)
        else $error("bus answer timing wrong");
    chk_idle_wait: assert property (!req |=> avs_waitrequest)
        else $error("waitrequest low while idle");
    chk_read_upper: assert property (rd_ok |-> avs_readdata[31:8] == 24'h0)
        else $error("upper read lanes not zero");
    chk_force_rd0: assert property (rd_ok && avs_address[4:2] == 3'h1
        |-> avs_readdata[7:6] == 2'b00)
        else $error("force strobes read back nonzero");
    chk_flags_rd: assert property (rd_ok && avs_address[4:2] == 3'h5
        |-> avs_readdata[7:3] == 5'h00)
        else $error("unused flag bits nonzero");
    chk_dir_hold: assert property ($changed(pin_a_oe_n) || $changed(pin_b_oe_n)
        |-> $past(wr_port, 2))
        else $error("pin direction moved without port write");
    chk_pin_source: assert property ($changed(pin_a_out)
        |-> $past(wr_src, 2) || $changed(waveform_output_a))
        else $error("pin output moved without cause");
    chk_irq_fall: assert property ($fell(irq_cmp_a)
        |-> $past(ack_cmp_a, 2) || $past(wr_irq, 2))
        else $error("compare irq dropped without cause");
endmodule // timer8_chk

bind timer8_counter_compare_core timer8_chk u_chk (.*);

// *** sim/tb_timer8_counter_compare_core.sv ***
`timescale 1ns/100ps
module tb_timer8_counter_compare_core;
    logic sys_clk = 1'b0;
    logic rst_n = 1'b0;
    logic clk_en = 1'b1;
    logic [4:0] avs_address = 5'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h00000000;
    logic [3:0] avs_byteenable = 4'hF;
    logic external_count_input = 1'b0;
    logic ack_ovf = 1'b0;
    logic ack_cmp_a = 1'b0;
    logic ack_cmp_b = 1'b0;
    wire [31:0] avs_readdata;
    wire avs_waitrequest;
    wire irq_ovf;
    wire irq_cmp_a;
    wire irq_cmp_b;
    wire waveform_output_a;
    wire waveform_output_b;
    wire pin_a_out;
    wire pin_a_oe_n;
    wire pin_b_out;
    wire pin_b_oe_n;
    int err_total = 0;
    int compares = 0;
    logic [31:0] exp_q[$];
    logic [7:0] rnd_b;
    logic [7:0] rnd_c;

    timer8_counter_compare_core dut (.*);

    always #4 sys_clk = ~sys_clk;

    task automatic test_done();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask

    // Holds the request until waitrequest is sampled low, then releases it.
    task automatic bus(input bit w, input logic [2:0] idx, input logic [7:0] d);
        int n;
        @(posedge sys_clk);
        avs_address <= {idx, 2'b00};
        avs_write <= w;
        avs_read <= !w;
        avs_writedata <= {24'h0, d};
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 50);
        if (avs_waitrequest !== 1'b0) begin
            err_total++;
            test_done();
        end
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask

    task automatic rdx(input logic [2:0] idx, input logic [7:0] e);
        exp_q.push_back({24'h0, e});
        bus(1'b0, idx, 8'h00);
    endtask

    // Lets the timer run from the system clock for a few ticks, then stops it.
    task automatic run3();
        bus(1'b1, 3'h1, 8'h01);
        bus(1'b1, 3'h1, 8'h00);
    endtask

    always @(posedge sys_clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            if (exp_q.size() > 0) check(avs_readdata, exp_q.pop_front());
            else check(avs_readdata, 32'hFFFFFFFF);
        end
    end

    initial begin
        void'($urandom(32'h2b9764e1));
        rnd_b = {2'b10, 6'($urandom)};
        rnd_c = 8'($urandom);
        tick(10);
        rst_n <= 1'b1;
        tick(2);
        check({waveform_output_a, waveform_output_b, pin_a_out, pin_b_out, irq_ovf,
            irq_cmp_a, irq_cmp_b, pin_a_oe_n, pin_b_oe_n}, 9'h003);
        for (int i = 0; i < 8; i++) rdx(3'(i), 8'h00);
        avs_byteenable <= 4'hE;
        bus(1'b1, 3'h2, 8'h5A);
        avs_byteenable <= 4'hF;
        rdx(3'h2, 8'h00);
        bus(1'b1, 3'h2, rnd_c);
        tick(20);
        rdx(3'h2, rnd_c);
        bus(1'b1, 3'h4, rnd_b);
        rdx(3'h4, rnd_b);
        bus(1'b1, 3'h3, 8'h10);
        bus(1'b1, 3'h2, 8'h0F);
        run3();
        rdx(3'h5, 8'h02);
        bus(1'b1, 3'h5, 8'h02);
        rdx(3'h5, 8'h00);
        bus(1'b1, 3'h3, 8'h20);
        bus(1'b1, 3'h2, 8'h20);
        run3();
        rdx(3'h5, 8'h00);
        bus(1'b1, 3'h2, 8'hFE);
        run3();
        rdx(3'h5, 8'h01);
        bus(1'b1, 3'h6, 8'h01);
        tick(2);
        check(irq_ovf, 1'b1);
        ack_ovf <= 1'b1;
        tick(1);
        ack_ovf <= 1'b0;
        bus(1'b1, 3'h6, 8'h02);
        bus(1'b1, 3'h2, 8'h1F);
        run3();
        tick(3);
        check({irq_ovf, irq_cmp_a, irq_cmp_b}, 3'b010);
        ack_cmp_a <= 1'b1;
        tick(1);
        ack_cmp_a <= 1'b0;
        tick(3);
        check(irq_cmp_a, 1'b0);
        rdx(3'h5, 8'h00);
        bus(1'b1, 3'h2, 8'h00);
        bus(1'b1, 3'h1, 8'h07);
        repeat (3) begin
            external_count_input <= 1'b1;
            tick(4);
            external_count_input <= 1'b0;
            tick(4);
        end
        bus(1'b1, 3'h1, 8'h00);
        rdx(3'h2, 8'h03);
        // With the clock enable low the running timer must not advance.
        bus(1'b1, 3'h1, 8'h01);
        clk_en <= 1'b0;
        tick(10);
        clk_en <= 1'b1;
        bus(1'b1, 3'h1, 8'h00);
        rdx(3'h2, 8'h06);
        bus(1'b1, 3'h7, 8'h11);
        tick(3);
        check({pin_a_out, pin_a_oe_n, pin_b_oe_n}, 3'b101);
        bus(1'b1, 3'h0, 8'h40);
        tick(3);
        check(pin_a_out, 1'b0);
        bus(1'b1, 3'h1, 8'h80);
        tick(3);
        check({waveform_output_a, pin_a_out}, 2'b11);
        rdx(3'h5, 8'h00);
        bus(1'b1, 3'h0, 8'h43);
        tick(3);
        check(waveform_output_a, 1'b1);
        bus(1'b1, 3'h3, 8'h77);
        rdx(3'h3, 8'h77);
        bus(1'b1, 3'h0, 8'h00);
        rdx(3'h3, 8'h20);
        bus(1'b1, 3'h1, 8'h80);
        tick(3);
        check({waveform_output_a, pin_a_out}, 2'b11);
        bus(1'b1, 3'h0, 8'h02);
        bus(1'b1, 3'h2, 8'h1E);
        run3();
        rdx(3'h2, 8'h00);
        rdx(3'h5, 8'h02);
        tick(2);
        check(32'(exp_q.size()), 32'h0);
        rst_n <= 1'b0;
        tick(3);
        rst_n <= 1'b1;
        tick(2);
        check({waveform_output_a, pin_a_out, pin_a_oe_n, irq_cmp_a}, 4'h2);
        test_done();
    end
endmodule // tb_timer8_counter_compare_core
